// File: rtl/ngts_device.sv
// Flash target end: busy timing, reset timing and enumeration chain.
`timescale 1ns/10ps
`default_nettype none
module ngts_device #(
    parameter int WB_CYC = ngts_pkg::C_WB_MAX,
    parameter int READ_CYC = ngts_pkg::C_READ,
    parameter int PROG_CYC = ngts_pkg::C_PROG,
    parameter int ERASE_CYC = ngts_pkg::C_ERASE,
    parameter int FEAT_CYC = ngts_pkg::C_FEAT,
    parameter int ITC_CYC = ngts_pkg::C_ITC,
    parameter int MP_SHORT_CYC = ngts_pkg::C_MP_SHORT,
    parameter int CACHE_SHORT_CYC = ngts_pkg::C_CACHE_SHORT,
    parameter int RST_IDLE_CYC = ngts_pkg::C_RST_IDLE,
    parameter int RST_PROG_CYC = ngts_pkg::C_RST_PROG,
    parameter int RST_ERASE_CYC = ngts_pkg::C_RST_ERASE
) (
    input wire logic clk,
    input wire logic rst_n,
    ngts_link_if.device link,
    input wire logic chain_enum_input,
    output logic chain_enum_output,
    output logic timing_violation
);
    localparam int CW = ngts_pkg::CNT_W;
    localparam int MP_ERASE_CYC = (MP_SHORT_CYC < ERASE_CYC) ? MP_SHORT_CYC : ERASE_CYC;
    localparam int MP_PROG_CYC = (MP_SHORT_CYC < PROG_CYC) ? MP_SHORT_CYC : PROG_CYC;
    localparam int MP_READ_CYC = (MP_SHORT_CYC < READ_CYC) ? MP_SHORT_CYC : READ_CYC;
    localparam int CP_CYC = (CACHE_SHORT_CYC < PROG_CYC) ? CACHE_SHORT_CYC : PROG_CYC;
    localparam int CR_CYC = (CACHE_SHORT_CYC < READ_CYC) ? CACHE_SHORT_CYC : READ_CYC;

    if (WB_CYC < 1 || READ_CYC < 1 || PROG_CYC < 1 || ERASE_CYC < 1 || FEAT_CYC < 1
        || ITC_CYC < 1 || MP_SHORT_CYC < 1 || CACHE_SHORT_CYC < 1 || RST_IDLE_CYC < 1
        || RST_PROG_CYC < RST_IDLE_CYC || RST_ERASE_CYC < 1 || ERASE_CYC >= 2 ** CW
        || RST_ERASE_CYC >= 2 ** CW || PROG_CYC >= 2 ** CW) begin : g_bad_param
        $error("ngts_device: cycle counts out of range");
    end

    typedef enum logic [3:0] {
        D_IDLE = 4'b0001, D_ARMED = 4'b0010, D_BUSY = 4'b0100, D_RESET = 4'b1000
    } ngts_dstate_e;

    ngts_dstate_e state;
    ngts_pkg::ngts_op_e op_q;
    logic [CW-1:0] cnt;
    logic [CW-1:0] wb_cnt;
    logic enabled;
    logic take;
    logic arm_go;
    logic [CW-1:0] rst_len;

    // The busy length of each operation; short busy never exceeds its full time.
    function automatic logic [CW-1:0] busy_len(input ngts_pkg::ngts_op_e op);
        unique case (op)
            ngts_pkg::OP_READ: return CW'(READ_CYC);
            ngts_pkg::OP_PROG: return CW'(PROG_CYC);
            ngts_pkg::OP_ERASE: return CW'(ERASE_CYC);
            ngts_pkg::OP_FEAT: return CW'(FEAT_CYC);
            ngts_pkg::OP_ITC: return CW'(ITC_CYC);
            ngts_pkg::OP_MP_ERASE: return CW'(MP_ERASE_CYC);
            ngts_pkg::OP_MP_PROG: return CW'(MP_PROG_CYC);
            ngts_pkg::OP_MP_READ: return CW'(MP_READ_CYC);
            ngts_pkg::OP_CACHE_PROG: return CW'(CP_CYC);
            ngts_pkg::OP_CACHE_READ: return CW'(CR_CYC);
            default: return CW'(1);
        endcase
    endfunction : busy_len

    ////////////////////////////////////////////////////////////////////////////
    // Command acceptance.
    // chain gated commands
    assign enabled = !link.ce_n && chain_enum_input;
    assign take = enabled && link.cmd_strobe;
    assign arm_go = enabled && (ngts_pkg::is_prog_op(op_q) ? link.data_strobe : link.p4_strobe);
    assign rst_len = (state == D_BUSY && ngts_pkg::is_prog_op(op_q)) ? CW'(RST_PROG_CYC) :
                     (state == D_BUSY && ngts_pkg::is_erase_op(op_q)) ? CW'(RST_ERASE_CYC) :
                     CW'(RST_IDLE_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // Operation sequencing.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= D_IDLE;
            op_q <= ngts_pkg::OP_READ;
            cnt <= '0;
        end else if (take && link.cmd_op == ngts_pkg::OP_RESET) begin
            state <= D_RESET;
            op_q <= ngts_pkg::OP_RESET;
            cnt <= rst_len;
        end else begin
            unique case (state)
                D_IDLE: begin
                    if (take && ngts_pkg::is_busy_op(link.cmd_op)) begin
                        op_q <= link.cmd_op;
                        if (ngts_pkg::is_prog_op(link.cmd_op) || (link.cmd_op == ngts_pkg::OP_FEAT
                            && link.iface_mode == ngts_pkg::MODE_DDR2)) begin
                            state <= D_ARMED;
                        end else begin
                            state <= D_BUSY;
                            cnt <= busy_len(link.cmd_op);
                        end
                    end
                end
                D_ARMED: begin
                    if (arm_go) begin
                        state <= D_BUSY;
                        cnt <= busy_len(op_q);
                    end
                end
                D_BUSY, D_RESET: begin
                    cnt <= cnt - CW'(1);
                    if (cnt == CW'(1)) begin
                        state <= D_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status bit and ready/busy follow the busy states one cycle later.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.status_ready <= 1'b1;
            link.rb_n <= 1'b1;
        end else begin
            link.status_ready <= !(state == D_BUSY || state == D_RESET);
            link.rb_n <= !(state == D_BUSY || state == D_RESET);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // A command or output strobe inside the busy_start_delay window is flagged and held.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_cnt <= '0;
            timing_violation <= 1'b0;
        end else begin
            if ((state == D_IDLE && take && ngts_pkg::is_busy_op(link.cmd_op)) || take
                || (state == D_ARMED && arm_go)) begin
                wb_cnt <= CW'(WB_CYC);
            end else if (wb_cnt != '0) begin
                wb_cnt <= wb_cnt - CW'(1);
            end
            if (wb_cnt != '0 && enabled && (link.cmd_strobe || link.out_strobe)) begin
                timing_violation <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enumeration output follows chip enable after one cycle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chain_enum_output <= 1'b1;
        end else begin
            chain_enum_output <= link.ce_n;
        end
    end

endmodule : ngts_device
`default_nettype wire

// File: rtl/ngts_host.sv
// Host end: issues operations and keeps every wait and busy poll of the flash target.
`timescale 1ns/10ps
`default_nettype none
// Function
// - first parameter read uses fixed waits
// - later reads use reported waits
// - reset limit depends on operation
// - ready/busy low throughout reset
// - status bit drops within busy_start_delay
// - no command inside busy_start_delay
// - feature busy starts at fourth byte in DDR2 mode, at the command otherwise
// - address_to_data_load_delay before data
// - input_to_output_turnaround before data output
// - column_change_setup after column change
// - status bit low during feature/mode change
// - use reported durations, fixed short limits
// - multiplane short busy bounded by full
// - cache busy polled, longer busy tolerated
// - pin reduction configured in single rate
// - volume_select_command_gap before next command
// - chip enable low volume_select_deselect_gap
// - enumeration input low ignores commands
// - enumeration output low after chip enable
// - host meets every timing limit
module ngts_host #(
    parameter int WB_CYC = ngts_pkg::C_WB_MIN,
    parameter int ADL_CYC = ngts_pkg::C_ADL_MIN,
    parameter int WHR_CYC = ngts_pkg::C_WHR_MIN,
    parameter int VDLY_CYC = ngts_pkg::C_VDLY_MIN,
    parameter int CEVDLY_CYC = ngts_pkg::C_CEVDLY_MIN,
    parameter int READ_INIT_CYC = ngts_pkg::C_READ_INIT_MIN,
    parameter int CCS_INIT_CYC = ngts_pkg::C_CCS_INIT_MIN,
    parameter int MP_POLL_CYC = ngts_pkg::C_MP_POLL,
    parameter int CACHE_POLL_CYC = ngts_pkg::C_CACHE_POLL
) (
    input wire logic clk,
    input wire logic rst_n,
    ngts_link_if.host link,
    input wire logic op_valid,
    input wire ngts_pkg::ngts_op_e op_code,
    input wire ngts_pkg::ngts_mode_e iface_mode_in,
    input wire logic init_done,
    input wire logic [ngts_pkg::CNT_W-1:0] cfg_read_cyc,
    input wire logic [ngts_pkg::CNT_W-1:0] cfg_ccs_cyc,
    output logic op_accept,
    output logic op_refused,
    output logic op_done
);
    localparam int CW = ngts_pkg::CNT_W;
    localparam int SEL_CYC = (VDLY_CYC > CEVDLY_CYC) ? VDLY_CYC : CEVDLY_CYC;
    // programmable rounded wait counts
    // A volume command is also followed by the busy_start_delay before the next command.
    localparam int VOL_CYC = (SEL_CYC > WB_CYC) ? SEL_CYC : WB_CYC;

    if (WB_CYC < 1 || ADL_CYC < 1 || WHR_CYC < 1 || VDLY_CYC < 1 || CEVDLY_CYC < 1
        || READ_INIT_CYC < 1 || CCS_INIT_CYC < 1 || MP_POLL_CYC < 1 || CACHE_POLL_CYC < 1
        || READ_INIT_CYC >= 2 ** CW) begin : g_bad_param
        $error("ngts_host: wait counts out of range");
    end

    typedef enum logic [8:0] {
        H_IDLE = 9'b000000001,
        H_CMD = 9'b000000010,
        H_LOAD = 9'b000000100,
        H_P4 = 9'b000001000,
        H_WB = 9'b000010000,
        H_WAIT = 9'b000100000,
        H_POLL = 9'b001000000,
        H_GAP = 9'b010000000,
        H_DONE = 9'b100000000
    } ngts_hstate_e;

    ngts_hstate_e state;
    ngts_pkg::ngts_op_e op_q;
    logic [CW-1:0] cnt;
    logic cnt_last;
    logic start;
    logic refuse;
    logic [CW-1:0] poll_len;
    logic [CW-1:0] gap_len;
    logic ready_seen;

    assign cnt_last = cnt == CW'(1);
    // pin reduction setup in single rate
    assign refuse = op_code == ngts_pkg::OP_VOL_APPOINT && iface_mode_in != ngts_pkg::MODE_SDR;
    assign start = state == H_IDLE && op_valid && !refuse;
    assign poll_len = (op_q == ngts_pkg::OP_CACHE_READ || op_q == ngts_pkg::OP_CACHE_PROG) ?
                      CW'(CACHE_POLL_CYC) :
                      (op_q == ngts_pkg::OP_MP_READ || op_q == ngts_pkg::OP_MP_PROG
                       || op_q == ngts_pkg::OP_MP_ERASE) ? CW'(MP_POLL_CYC) : CW'(1);
    assign gap_len = (op_q == ngts_pkg::OP_COL_CHANGE) ?
                     (init_done ? cfg_ccs_cyc : CW'(CCS_INIT_CYC)) :
                     (op_q == ngts_pkg::OP_STATUS || op_q == ngts_pkg::OP_READ_ID) ?
                     CW'(WHR_CYC) : CW'(VOL_CYC);
    // Reset completion is seen on ready/busy, other operations on the status bit.
    assign ready_seen = (op_q == ngts_pkg::OP_RESET) ? link.rb_n : link.status_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Operation sequencing and wait counting.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= H_IDLE;
            op_q <= ngts_pkg::OP_READ;
            cnt <= '0;
        end else begin
            unique case (state)
                H_IDLE: begin
                    if (start) begin
                        op_q <= op_code;
                        state <= H_CMD;
                    end
                end
                H_CMD: begin
                    if (ngts_pkg::is_prog_op(op_q)) begin
                        state <= H_LOAD;
                        cnt <= CW'(ADL_CYC);
                    end else if (op_q == ngts_pkg::OP_FEAT
                                 && link.iface_mode == ngts_pkg::MODE_DDR2) begin
                        state <= H_P4;
                    end else if (ngts_pkg::is_busy_op(op_q)) begin
                        state <= H_WB;
                        cnt <= CW'(WB_CYC);
                    end else begin
                        state <= H_GAP;
                        cnt <= gap_len;
                    end
                end
                H_LOAD: begin
                    cnt <= cnt - CW'(1);
                    if (cnt_last) begin
                        state <= H_WB;
                        cnt <= CW'(WB_CYC) + CW'(1);
                    end
                end
                H_P4: begin
                    state <= H_WB;
                    cnt <= CW'(WB_CYC) + CW'(1);
                end
                H_WB: begin
                    cnt <= cnt - CW'(1);
                    if (cnt_last) begin
                        if (op_q == ngts_pkg::OP_READ) begin
                            state <= H_WAIT;
                            cnt <= init_done ? cfg_read_cyc : CW'(READ_INIT_CYC);
                        end else begin
                            state <= H_POLL;
                            cnt <= poll_len;
                        end
                    end
                end
                H_WAIT: begin
                    cnt <= cnt - CW'(1);
                    if (cnt_last) begin
                        state <= H_POLL;
                        cnt <= poll_len;
                    end
                end
                H_POLL: begin
                    cnt <= cnt - CW'(1);
                    if (cnt_last) begin
                        if (ready_seen) begin
                            state <= H_DONE;
                        end else begin
                            cnt <= poll_len;
                        end
                    end
                end
                H_GAP: begin
                    cnt <= cnt - CW'(1);
                    if (cnt_last) begin
                        state <= H_DONE;
                    end
                end
                H_DONE: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link strobes, chip enable and user handshake, all registered.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.ce_n <= 1'b1;
            link.cmd_strobe <= 1'b0;
            link.cmd_op <= ngts_pkg::OP_READ;
            link.data_strobe <= 1'b0;
            link.p4_strobe <= 1'b0;
            link.out_strobe <= 1'b0;
            link.iface_mode <= ngts_pkg::MODE_SDR;
            op_accept <= 1'b0;
            op_refused <= 1'b0;
            op_done <= 1'b0;
        end else begin
            link.iface_mode <= iface_mode_in;
            if (start) begin
                link.ce_n <= 1'b0;
            end else if (state == H_DONE) begin
                link.ce_n <= 1'b1;
            end
            link.cmd_strobe <= state == H_CMD;
            if (state == H_CMD) begin
                link.cmd_op <= op_q;
            end
            link.data_strobe <= state == H_LOAD && cnt_last;
            link.p4_strobe <= state == H_P4;
            link.out_strobe <= state == H_GAP && cnt_last
                               && (op_q == ngts_pkg::OP_STATUS || op_q == ngts_pkg::OP_READ_ID);
            op_accept <= state == H_IDLE && op_valid;
            op_refused <= state == H_IDLE && op_valid && refuse;
            op_done <= state == H_DONE;
        end
    end

endmodule : ngts_host
`default_nettype wire

// File: rtl/ngts_link_if.sv
// Command, strobe and status link between the host sequencer and the flash target.
`timescale 1ns/10ps
`default_nettype none
interface ngts_link_if (
    input wire logic clk
);
    logic ce_n;
    logic cmd_strobe;
    ngts_pkg::ngts_op_e cmd_op;
    logic data_strobe;
    logic p4_strobe;
    logic out_strobe;
    ngts_pkg::ngts_mode_e iface_mode;
    logic rb_n;
    logic status_ready;

    modport host (
        output ce_n, cmd_strobe, cmd_op, data_strobe, p4_strobe, out_strobe, iface_mode,
        input rb_n, status_ready
    );

    modport device (
        input ce_n, cmd_strobe, cmd_op, data_strobe, p4_strobe, out_strobe, iface_mode,
        output rb_n, status_ready
    );
endinterface : ngts_link_if
`default_nettype wire

// File: rtl/ngts_pkg.sv
// Shared constants, operation codes and phase predicates of the NAND timing sequencer pair.
package ngts_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and counter width.
    localparam int CLK_NS = 8;
    localparam int CNT_W = 24;

    ////////////////////////////////////////////////////////////////////////////
    // Fixed times in nanoseconds.
    localparam int T_READ_INIT_NS = 200000;
    localparam int T_CCS_INIT_NS = 500;
    localparam int T_MP_SHORT_NS = 500;
    localparam int T_CACHE_SHORT_NS = 3000;
    localparam int T_VDLY_NS = 50;
    localparam int T_CEVDLY_NS = 50;
    localparam int T_ENI_NS = 15;
    localparam int T_ENO_NS = 50;

    // Times that a part reports or that vary by part; plain defaults.
    localparam int T_WB_NS = 100;
    localparam int T_ADL_NS = 200;
    localparam int T_WHR_NS = 120;
    localparam int T_FEAT_NS = 1000;
    localparam int T_ITC_NS = 1000;
    localparam int T_READ_NS = 50000;
    localparam int T_CCS_NS = 300;
    localparam int T_PROG_NS = 600000;
    localparam int T_ERASE_NS = 3000000;
    localparam int T_RST_IDLE_NS = 5000;
    localparam int T_RST_PROG_NS = 10000;
    localparam int T_RST_ERASE_NS = 500000;

    ////////////////////////////////////////////////////////////////////////////
    // Least waits round up, longest durations round down, none below one cycle.
    localparam int C_READ_INIT_MIN = (T_READ_INIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_CCS_INIT_MIN = (T_CCS_INIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_WB_MIN = (T_WB_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_ADL_MIN = (T_ADL_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_WHR_MIN = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_VDLY_MIN = (T_VDLY_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_CEVDLY_MIN = (T_CEVDLY_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_MP_POLL = (T_MP_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_CACHE_POLL = (T_CACHE_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_WB_MAX = (T_WB_NS < CLK_NS) ? 1 : T_WB_NS / CLK_NS;
    localparam int C_ENI_MAX = (T_ENI_NS < CLK_NS) ? 1 : T_ENI_NS / CLK_NS;
    localparam int C_ENO_MAX = (T_ENO_NS < CLK_NS) ? 1 : T_ENO_NS / CLK_NS;
    localparam int C_MP_SHORT = (T_MP_SHORT_NS < CLK_NS) ? 1 : T_MP_SHORT_NS / CLK_NS;
    localparam int C_CACHE_SHORT = (T_CACHE_SHORT_NS < CLK_NS) ? 1 : T_CACHE_SHORT_NS / CLK_NS;
    localparam int C_FEAT = (T_FEAT_NS < CLK_NS) ? 1 : T_FEAT_NS / CLK_NS;
    localparam int C_ITC = (T_ITC_NS < CLK_NS) ? 1 : T_ITC_NS / CLK_NS;
    localparam int C_READ = (T_READ_NS < CLK_NS) ? 1 : T_READ_NS / CLK_NS;
    localparam int C_CCS = (T_CCS_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_PROG = (T_PROG_NS < CLK_NS) ? 1 : T_PROG_NS / CLK_NS;
    localparam int C_ERASE = (T_ERASE_NS < CLK_NS) ? 1 : T_ERASE_NS / CLK_NS;
    localparam int C_RST_IDLE = (T_RST_IDLE_NS < CLK_NS) ? 1 : T_RST_IDLE_NS / CLK_NS;
    localparam int C_RST_PROG = (T_RST_PROG_NS < CLK_NS) ? 1 : T_RST_PROG_NS / CLK_NS;
    localparam int C_RST_ERASE = (T_RST_ERASE_NS < CLK_NS) ? 1 : T_RST_ERASE_NS / CLK_NS;

    ////////////////////////////////////////////////////////////////////////////
    // Operations and interface modes.
    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_PROG = 4'h1, OP_ERASE = 4'h2, OP_FEAT = 4'h3,
        OP_ITC = 4'h4, OP_RESET = 4'h5, OP_STATUS = 4'h6, OP_READ_ID = 4'h7,
        OP_COL_CHANGE = 4'h8, OP_VOL_SELECT = 4'h9, OP_CACHE_READ = 4'ha,
        OP_CACHE_PROG = 4'hb, OP_MP_READ = 4'hc, OP_MP_PROG = 4'hd,
        OP_MP_ERASE = 4'he, OP_VOL_APPOINT = 4'hf
    } ngts_op_e;

    typedef enum logic [1:0] {
        MODE_SDR = 2'h0, MODE_DDR = 2'h1, MODE_DDR2 = 2'h2
    } ngts_mode_e;

    function automatic logic is_prog_op(input ngts_op_e op);
        return op == OP_PROG || op == OP_CACHE_PROG || op == OP_MP_PROG;
    endfunction : is_prog_op

    function automatic logic is_erase_op(input ngts_op_e op);
        return op == OP_ERASE || op == OP_MP_ERASE;
    endfunction : is_erase_op

    function automatic logic is_busy_op(input ngts_op_e op);
        return !(op == OP_STATUS || op == OP_READ_ID || op == OP_COL_CHANGE
                 || op == OP_VOL_SELECT || op == OP_VOL_APPOINT);
    endfunction : is_busy_op

endpackage : ngts_pkg

// File: test/nand_general_timing_sequencer_tb.sv
// Self-checking bench joining host and flash target over the link.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module nand_general_timing_sequencer_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    ngts_pkg::ngts_op_e op_code = ngts_pkg::OP_READ;
    ngts_pkg::ngts_mode_e iface_mode_in = ngts_pkg::MODE_SDR;
    logic init_done = 1'b0;
    logic [23:0] cfg_read_cyc = 24'h000014;
    logic [23:0] cfg_ccs_cyc = 24'h00000e;
    logic chain_enum_input = 1'b1;
    logic op_accept, op_refused, op_done, chain_enum_output, timing_violation;
    logic [15:0] exp_q[$];
    logic [15:0] exp_v;
    logic [15:0] busy_cnt = 16'h0000;
    logic [31:0] seed = 32'ha1d2a992;
    int checks = 0, mismatches = 0, cycles = 0;
    // Busy cycles each operation code should show on the status bit.
    localparam logic [15:0] BUSY [16] = '{16'h0014, 16'h001e, 16'h0028,
        16'(ngts_pkg::C_FEAT), 16'(ngts_pkg::C_ITC), 16'(ngts_pkg::C_RST_IDLE),
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0014, 16'h001e, 16'h0014,
        16'h001e, 16'h0028, 16'h0000};
    always #4 clk = ~clk;
    ngts_link_if link (.clk(clk));
    ngts_host #(.READ_INIT_CYC(30)) ngts_host_i (.clk(clk), .rst_n(rst_n), .link(link.host),
        .op_valid(op_valid), .op_code(op_code), .iface_mode_in(iface_mode_in),
        .init_done(init_done), .cfg_read_cyc(cfg_read_cyc), .cfg_ccs_cyc(cfg_ccs_cyc),
        .op_accept(op_accept), .op_refused(op_refused), .op_done(op_done));
    ngts_device #(.READ_CYC(20), .PROG_CYC(30), .ERASE_CYC(40)) ngts_device_i (.clk(clk),
        .rst_n(rst_n), .link(link.device),
        .chain_enum_input(chain_enum_input), .chain_enum_output(chain_enum_output),
        .timing_violation(timing_violation));
    ngts_link_assertions ngts_link_assertions_i (.clk(clk), .rst_n(rst_n), .ce_n(link.ce_n),
        .cmd_strobe(link.cmd_strobe), .cmd_op(link.cmd_op), .data_strobe(link.data_strobe),
        .p4_strobe(link.p4_strobe), .out_strobe(link.out_strobe),
        .iface_mode(link.iface_mode), .rb_n(link.rb_n), .status_ready(link.status_ready),
        .chain_enum_input(chain_enum_input));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic finish_test();
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic do_op(input logic [3:0] op, input logic [1:0] mode);
        logic refd;
        op_code = ngts_pkg::ngts_op_e'(op);
        iface_mode_in = ngts_pkg::ngts_mode_e'(mode);
        op_valid = 1'b1;
        if (op == 4'hf && mode != 2'h0) exp_q.push_back(16'hffff);
        else exp_q.push_back(chain_enum_input ? BUSY[op] : 16'h0000);
        @(negedge clk iff op_accept);
        refd = op_refused;
        op_valid = 1'b0;
        if (!refd) begin
            @(negedge clk);
            `CHK("enum_out", 1'b0, chain_enum_output)
            @(negedge clk iff op_done);
        end else begin
            @(negedge clk);
        end
    endtask : do_op
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (!link.status_ready) busy_cnt++;
        if (op_done || op_refused) begin
            exp_v = exp_q.pop_front();
            `CHK("busy_len", exp_v, op_refused ? 16'hffff : busy_cnt)
            busy_cnt = 16'h0000;
        end
    end
    always @(negedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        logic [31:0] r;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 16; i++) begin
            do_op(i[3:0], 2'h0);
            init_done = 1'b1;
        end
        do_op(4'hf, 2'h1);
        do_op(4'h3, 2'h2);
        chain_enum_input = 1'b0;
        do_op(4'h2, 2'h0);
        chain_enum_input = 1'b1;
        repeat (30) begin
            r = rnd();
            cfg_read_cyc = 24'(r[7:0] % 40 + 1);
            cfg_ccs_cyc = 24'(r[15:8] % 16 + 14);
            do_op(r[19:16], 2'(r[27:20] % 3));
        end
        repeat (5) @(negedge clk);
        `CHK("violation", 1'b0, timing_violation)
        finish_test();
    end
endmodule : nand_general_timing_sequencer_tb
`default_nettype wire

// File: test/ngts_link_assertions.sv
// Timing assertions on the link between host and flash target.
`timescale 1ns/10ps
`default_nettype none
module ngts_link_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce_n,
    input wire logic cmd_strobe,
    input wire ngts_pkg::ngts_op_e cmd_op,
    input wire logic data_strobe,
    input wire logic p4_strobe,
    input wire logic out_strobe,
    input wire ngts_pkg::ngts_mode_e iface_mode,
    input wire logic rb_n,
    input wire logic status_ready,
    input wire logic chain_enum_input
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic take;
    assign take = cmd_strobe && !ce_n && chain_enum_input;
    wb_gap_a: assert property (cmd_strobe |=> (!(cmd_strobe || out_strobe))[*8])
        else $error("command inside busy start delay");
    erase_busy_a: assert property (take && cmd_op == ngts_pkg::OP_ERASE |->
        ##2 !status_ready && !rb_n) else $error("erase busy late");
    reset_busy_a: assert property (take && cmd_op == ngts_pkg::OP_RESET |->
        ##2 (!rb_n)[*8]) else $error("reset ready line not low");
    feat_p4_a: assert property (p4_strobe && !ce_n && chain_enum_input |->
        ##2 !status_ready) else $error("fourth byte busy late");
    feat_busy_a: assert property (take && cmd_op == ngts_pkg::OP_FEAT
        && iface_mode != ngts_pkg::MODE_DDR2 |-> ##2 (!status_ready)[*8])
        else $error("feature status not low");
    adl_gap_a: assert property (cmd_strobe && cmd_op == ngts_pkg::OP_PROG |=>
        (!data_strobe)[*8]) else $error("data load too early");
    whr_gap_a: assert property (cmd_strobe && cmd_op == ngts_pkg::OP_STATUS |=>
        (!out_strobe)[*8]) else $error("data output too early");
    vol_hold_a: assert property (cmd_strobe && cmd_op == ngts_pkg::OP_VOL_SELECT |=>
        (!ce_n)[*6]) else $error("chip enable released early");
    appoint_sdr_a: assert property (cmd_strobe && cmd_op == ngts_pkg::OP_VOL_APPOINT |->
        iface_mode == ngts_pkg::MODE_SDR) else $error("pin reduction outside single rate");
endmodule : ngts_link_assertions
`default_nettype wire
